// ===== hdl/rbpc_buffer.sv
// Buffer end: parity check with role-dependent error latency.
`timescale 1ns/1ns
`include "rbpc_map.svh"
// Behaviour
// - Both selects low: single buffer, check all.
// - Pair roles: first 0/1, second 1/1.
// - Single or second: error at n+2.
// - First of pair: error at n+1.
// - Error held low at least two cycles.
// - Controller holds inputs low after reset.
// - Second parity input comes from first.
module rbpc_buffer #(
   parameter int DATA_W = `RBPC_DATA_W
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              config_select0,
   input  wire logic              config_select1,
   output logic [DATA_W-1:0]      out_data,
   output logic                   out_valid,
   input  wire logic              out_ready,
   output logic                   role_fault,
   rbpc_link_if.buffer            link
);
   import rbpc_pkg::*;

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   // The hold counter is two bits wide, so longer holds cannot be served.
   initial begin
      if (DATA_W < 1) begin
         $error("DATA_W must be at least one");
      end
      if (`RBPC_ERR_HOLD < 1 || `RBPC_ERR_HOLD > 4) begin
         $error("error hold must lie between one and four cycles");
      end
   end

   // ------------------------------------------------------------
   // Role decode
   // ------------------------------------------------------------
   // Select1 is the upper bit of the role code, so the first device of a
   // pair, with select0 low and select1 high, decodes as the first role.
   rbpc_role_e role;
   logic       is_single;
   logic       is_first;
   logic       is_second;
   logic       late_role;
   assign role      = rbpc_role_e'({config_select1, config_select0});
   assign is_single = (role == RBPC_SINGLE);
   assign is_first  = (role == RBPC_FIRST);
   assign is_second = (role == RBPC_SECOND);
   assign late_role = is_single || is_second;

   always_comb begin
      case (role)
         RBPC_SINGLE: begin
            role_fault = 1'b0;
         end
         RBPC_FIRST: begin
            role_fault = 1'b0;
         end
         RBPC_SECOND: begin
            role_fault = 1'b0;
         end
         default: begin
            role_fault = 1'b1;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Word parity
   // ------------------------------------------------------------
   // Only the parity of a word is kept, not the word itself, because the
   // late parity bit needs nothing more to be judged.
   logic data_par_ff;
   logic nxt_data_par;
   logic sum_odd;
   assign nxt_data_par = ^link.data;
   assign sum_odd      = data_par_ff ^ link.parity_in;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         data_par_ff <= 1'b0;
      end else begin
         data_par_ff <= nxt_data_par;
      end
   end

   // ------------------------------------------------------------
   // Partial parity out
   // ------------------------------------------------------------
   // The second device takes this on its parity input.
   logic ppo_ff;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ppo_ff <= 1'b0;
      end else begin
         ppo_ff <= sum_odd;
      end
   end

   assign link.partial_parity_out = ppo_ff;

   // ------------------------------------------------------------
   // Error staging
   // ------------------------------------------------------------
   // The late roles wait one more edge so that the pair reports an error
   // at the same edge as a single device would.
   logic err_stage_ff;
   logic err_first;
   logic err_late;
   logic err_now;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         err_stage_ff <= 1'b0;
      end else begin
         err_stage_ff <= sum_odd;
      end
   end

   assign err_first = is_first && sum_odd;
   assign err_late  = late_role && err_stage_ff;
   assign err_now   = err_first || err_late;

   // ------------------------------------------------------------
   // Error hold
   // ------------------------------------------------------------
   // A fresh error restarts the hold, so low lasts at least two cycles.
   logic [1:0] hold_ff;
   logic       hold_busy;
   assign hold_busy = (hold_ff != 2'h0);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hold_ff <= 2'h0;
      end else if (err_now) begin
         hold_ff <= 2'(`RBPC_ERR_HOLD - 1);
      end else if (hold_busy) begin
         hold_ff <= hold_ff - 2'h1;
      end
   end

   // ------------------------------------------------------------
   // Error output
   // ------------------------------------------------------------
   // The line is open drain: the buffer only ever pulls it low.
   logic err_n_ff;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         err_n_ff <= 1'b1;
      end else if (err_now) begin
         err_n_ff <= 1'b0;
      end else if (!hold_busy) begin
         err_n_ff <= 1'b1;
      end
   end

   assign link.parity_error_out_n_o  = 1'b0;
   assign link.parity_error_out_n_oe = ~err_n_ff;

   // ------------------------------------------------------------
   // Two-entry output buffer
   // ------------------------------------------------------------
   // Two entries let the link run back to back while the receiver keeps up; a stall
   // that meets an arriving word fills both and drops data_ready the next cycle.
   logic [DATA_W-1:0] mem [2];
   logic              wr_ff;
   logic              rd_ff;
   logic [1:0]        cnt_ff;
   logic              push;
   logic              pop;
   logic              buf_full;
   logic              buf_empty;
   assign buf_full        = (cnt_ff == 2'h2);
   assign buf_empty       = (cnt_ff == 2'h0);
   assign link.data_ready = !buf_full;
   assign push            = link.data_valid && link.data_ready;
   assign pop             = out_valid && out_ready;
   assign out_valid       = !buf_empty;
   assign out_data        = mem[rd_ff];

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ff <= 1'b0;
      end else if (push) begin
         wr_ff <= ~wr_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rd_ff <= 1'b0;
      end else if (pop) begin
         rd_ff <= ~rd_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_ff <= 2'h0;
      end else begin
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end

   // Entries need no reset: the count alone says which ones hold data.
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ff] <= link.data;
      end
   end
endmodule // rbpc_buffer

// ===== hdl/rbpc_ctrl.sv
// Controller end: drives data words and their late parity bit onto the link.
`timescale 1ns/1ns
`include "rbpc_map.svh"
module rbpc_ctrl #(
   parameter int DATA_W = `RBPC_DATA_W
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic [DATA_W-1:0] usr_data,
   input  wire logic              usr_valid,
   output logic                   usr_ready,
   input  wire logic              usr_bad_parity,
   output logic                   usr_error,
   rbpc_link_if.ctrl              link
);
   import rbpc_pkg::*;

   initial begin
      if (DATA_W < 1) $error("DATA_W must be at least one");
   end

   // ------------------------------------------------------------
   // Quiet time after reset
   // ------------------------------------------------------------
   logic [3:0]        quiet_ff;
   logic [DATA_W-1:0] data_ff;
   logic              par_ff;
   logic              vld_ff;
   logic              quiet_done;
   assign quiet_done = (quiet_ff == 4'(`RBPC_ACT_CYC));
   // A word stays on the link until the buffer takes it, so a stall loses nothing.
   assign usr_ready  = quiet_done && (!vld_ff || link.data_ready);

   // Data and parity stay low until the receivers are active.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         quiet_ff <= 4'h0;
      end else if (!quiet_done) begin
         quiet_ff <= quiet_ff + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // Word and parity launch
   // ------------------------------------------------------------
   // Parity follows its word by one cycle, so it is registered from the word.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         data_ff <= '0;
         vld_ff  <= 1'b0;
      end else if (usr_ready) begin
         data_ff <= usr_valid ? usr_data : '0;
         vld_ff  <= usr_valid;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         par_ff <= 1'b0;
      end else begin
         par_ff <= (^data_ff) ^ (vld_ff && usr_bad_parity);
      end
   end

   assign link.data       = data_ff;
   assign link.data_valid = vld_ff;
   assign link.parity_in  = par_ff;
   assign usr_error       = ~link.parity_error_out_n;
endmodule // rbpc_ctrl

// ===== hdl/rbpc_link_if.sv
// Interface joining the memory controller to the parity-checking buffer.
`timescale 1ns/1ns
interface rbpc_link_if #(parameter int DATA_W = 14);
   logic [DATA_W-1:0] data;
   logic              parity_in;
   logic              parity_error_out_n_o;
   logic              parity_error_out_n_oe;
   logic              partial_parity_out;
   logic              data_valid;
   logic              data_ready;
   logic              parity_error_out_n;

   // The error line is open drain and pulled up when nobody drives it.
   assign parity_error_out_n = parity_error_out_n_oe ? parity_error_out_n_o : 1'b1;

   modport buffer (
      input  data, parity_in, data_valid,
      output parity_error_out_n_o, parity_error_out_n_oe, partial_parity_out, data_ready
   );
   modport ctrl (
      output data, parity_in, data_valid,
      input  parity_error_out_n, partial_parity_out, data_ready
   );
endinterface

// ===== hdl/rbpc_map.svh
// Constants for the registered buffer parity check block.
`ifndef RBPC_MAP_SVH
`define RBPC_MAP_SVH
`define RBPC_DATA_W      14
`define RBPC_ERR_HOLD    2
`define RBPC_ACT_NS      10
`define RBPC_CLK_NS      10
`define RBPC_ACT_CYC     ((`RBPC_ACT_NS + `RBPC_CLK_NS - 1) / `RBPC_CLK_NS)
`define RBPC_CFG_SINGLE  2'b00
`define RBPC_CFG_FIRST   2'b10
`define RBPC_CFG_SECOND  2'b11
`endif

// ===== hdl/rbpc_pkg.sv
// Types shared by both ends of the parity check link.
package rbpc_pkg;
   typedef enum logic [1:0] {
      RBPC_SINGLE = 2'b00,
      RBPC_FIRST  = 2'b10,
      RBPC_SECOND = 2'b11,
      RBPC_BAD    = 2'b01
   } rbpc_role_e;
endpackage

// ===== testbench/rbpc_link_monitor.sv
// Assertions on the link between controller and buffer.
`timescale 1ns/1ns
module rbpc_link_monitor #(parameter int DATA_W = 14) (
   input wire logic              sys_clk,
   input wire logic              rst_n,
   input wire logic              config_select0,
   input wire logic              config_select1,
   input wire logic [DATA_W-1:0] data,
   input wire logic              parity_in,
   input wire logic              parity_error_out_n,
   input wire logic              partial_parity_out
);
   // The parity bit trails its word by one cycle, so the word is kept here.
   logic [DATA_W-1:0] data_ff;
   logic              bad;
   logic              late;
   logic              first;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         data_ff <= '0;
      end else begin
         data_ff <= data;
      end
   end
   assign bad   = (^data_ff) ^ parity_in;
   assign late  = config_select0 == config_select1;
   assign first = !config_select0 && config_select1;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence err_seen;
      !parity_error_out_n;
   endsequence
   a_late_err_lat: assert property (late && bad |-> ##2 err_seen)
      else $error("late role error missing");
   a_first_err_lat: assert property (first && bad |-> ##1 err_seen)
      else $error("first role error missing");
   a_late_no_false: assert property (late && $fell(parity_error_out_n) |-> $past(bad, 2))
      else $error("late role false error");
   a_first_no_false: assert property (first && $fell(parity_error_out_n) |-> $past(bad))
      else $error("first role false error");
   a_err_hold_two: assert property ($fell(parity_error_out_n) |=> err_seen)
      else $error("error released too early");
   a_ppo_sum: assert property (partial_parity_out == $past(bad))
      else $error("partial parity wrong");
   a_reset_release: assert property ($rose(rst_n) |-> parity_error_out_n && !partial_parity_out)
      else $error("outputs not cleared by reset");
   a_quiet_start: assert property ($rose(rst_n) |-> (!(|data) && !parity_in) [*2])
      else $error("inputs not quiet after reset");
endmodule // rbpc_link_monitor

// ===== testbench/rbpc_tb.sv
// Self-checking bench for the controller and buffer joined by the link.
`timescale 1ns/1ns
module rbpc_tb;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        s0 = 1'b0;
   logic        s1 = 1'b0;
   logic [13:0] usr_data = 14'h0000;
   logic        usr_valid = 1'b0;
   logic        bad_par = 1'b0;
   logic        out_ready = 1'b0;
   logic        usr_ready, usr_error, out_valid, role_fault, saw_err;
   logic [13:0] out_data;
   logic [13:0] sent_q[$];
   int          fails = 0;
   int          samples_checked = 0;
   rbpc_link_if #(.DATA_W(14)) rbpc_link_if_inst ();
   rbpc_ctrl #(.DATA_W(14)) rbpc_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .usr_data(usr_data), .usr_valid(usr_valid), .usr_ready(usr_ready),
      .usr_bad_parity(bad_par), .usr_error(usr_error), .link(rbpc_link_if_inst.ctrl));
   rbpc_buffer #(.DATA_W(14)) rbpc_buffer_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .config_select0(s0), .config_select1(s1), .out_data(out_data), .out_valid(out_valid),
      .out_ready(out_ready), .role_fault(role_fault), .link(rbpc_link_if_inst.buffer));
   rbpc_link_monitor #(.DATA_W(14)) rbpc_link_monitor_inst (.sys_clk(sys_clk),
      .rst_n(rst_n), .config_select0(s0), .config_select1(s1),
      .data(rbpc_link_if_inst.data), .parity_in(rbpc_link_if_inst.parity_in),
      .parity_error_out_n(rbpc_link_if_inst.parity_error_out_n),
      .partial_parity_out(rbpc_link_if_inst.partial_parity_out));
   always #5 sys_clk = ~sys_clk;
   task automatic check_bit(string what, logic exp, logic got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %0b seen %0b", what, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic want_err(int nbad);
      return nbad != 0;
   endfunction
   // The receiver stalls at random, so the two-entry buffer must hold words back.
   always @(posedge sys_clk) begin
      out_ready <= ($urandom % 4) != 0;
      if (rst_n && out_valid && out_ready) begin
         samples_checked++;
         if (sent_q.size() == 0 || out_data !== sent_q[0]) begin
            fails++;
            $display("CHECK FAILED out_data expected queued seen %h", out_data);
         end
         if (sent_q.size() != 0) void'(sent_q.pop_front());
      end
   end
   task automatic run_role(logic a, logic b, logic inject);
      int n;
      int nbad;
      logic hit;
      n = 0;
      nbad = 0;
      saw_err = 1'b0;
      rst_n <= 1'b0;
      s0 <= a;
      s1 <= b;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      usr_valid <= 1'b1;
      usr_data <= 14'($urandom);
      check_bit("role_fault", 1'b0, role_fault);
      for (int i = 0; i < 120; i++) begin
         @(posedge sys_clk);
         saw_err = saw_err | usr_error;
         hit = 1'b0;
         if (usr_valid && usr_ready) begin
            sent_q.push_back(usr_data);
            n++;
            usr_data <= 14'($urandom);
            usr_valid <= n < 30;
            if (inject && (($urandom % 6) == 0 || n == 30)) begin
               hit = 1'b1;
               nbad++;
            end
         end
         bad_par <= hit;
      end
      if (sent_q.size() != 0 || n != 30) begin
         check_bit("drained", 1'b1, 1'b0);
         final_report();
      end
      check_bit("error_seen", want_err(nbad), saw_err);
      check_bit("error_idle", 1'b0, usr_error);
      $display("test role %b%b inject %b done", a, b, inject);
   endtask
   initial begin
      void'($urandom(58342));
      run_role(1'b0, 1'b0, 1'b1);
      run_role(1'b0, 1'b1, 1'b1);
      run_role(1'b1, 1'b1, 1'b1);
      run_role(1'b0, 1'b0, 1'b0);
      s0 <= 1'b1;
      s1 <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check_bit("role_fault", 1'b1, role_fault);
      final_report();
   end
endmodule // rbpc_tb
